// ===== src/clk_ctrl_cfg.svh
// register map, field positions, reset values and timing of the clock control block
// Overview of operation
// - every register access completes three clk_in cycles after it is taken
// - access to an unpopulated address answers with a bus error
// - wake-up timers run on the slow clock, everything else on the fast clock
// - fast clock source is either the fast crystal or the fast RC oscillator
// - slow clock source is the slow RC, the slow crystal or an external clock
// - radio gets the fast clock undivided, peripherals get it divided by two
// - processor clock is the fast clock divided by 1, 2, 4, 8, 16 or 32
// - after reset or sleep the fast clock always starts on the RC oscillator
// - on wake: auto switch to crystal, switch on software request, or stay on RC
// - fast clock moves to the crystal only once its ready flag is set
// - fast RC trim setting is kept across speed changes and oscillator off
// - slow clock times sleep; software picks its source
// - slow clock source defaults to the RC oscillator after reset
// - once another slow source is chosen it stays until the next reset
// - a calibration factor for the slow RC oscillator can be applied
// - slow RC oscillator has an optional reduced-current setting
`ifndef CLK_CTRL_CFG_SVH
`define CLK_CTRL_CFG_SVH

`define OFS_HS_CTRL     8'h00
`define OFS_HS_TRIM     8'h04
`define OFS_LS_CTRL     8'h08
`define OFS_LS_CAL      8'h0c
`define OFS_STATUS      8'h10
`define OFS_IRQ_STAT    8'h14
`define OFS_IRQ_MASK    8'h18

`define F_HS_MODE       1:0
`define F_HS_REQ        2
`define F_HS_DIV        5:3
`define F_TRIM          7:0
`define F_LS_SRC        1:0
`define F_LS_LOWI       2
`define F_CAL_LO        7:0
`define F_CAL_HI        15:8
`define F_IRQ           2:0

`define IRQ_BUSERR      0
`define IRQ_XSWAP       1
`define IRQ_XRDY        2

`define HS_MODE_AUTO    2'h0
`define HS_MODE_SW      2'h1
`define HS_MODE_STAY    2'h2
`define LS_SRC_RC       2'h0
`define LS_SRC_XTAL     2'h1
`define LS_SRC_EXT      2'h2
`define DIV_MAX         3'h5

`define RST_HS_MODE     2'h0
`define RST_DIV         3'h0
`define RST_TRIM        8'h00
`define RST_LS_CAL      16'h0000
`define RST_IRQ_MASK    3'h0

`define RESP_OKAY       2'h0
`define RESP_DECERR     2'h3

`define ACCESS_CYCLES   2'h3
`define CLK_PERIOD_NS   20
`define LS_RUN_WIN_NS   62500
`define LS_RUN_WIN_CYC  12'(`LS_RUN_WIN_NS / `CLK_PERIOD_NS)

`endif

// ===== src/clk_ctrl_pkg.sv
// types shared by the clock control block
`default_nettype none
package clk_ctrl_pkg;
    typedef enum logic [1:0] {
        HS_RC   = 2'h0,
        HS_WAIT = 2'h1,
        HS_SWAP = 2'h3,
        HS_XTAL = 2'h2
    } hs_state_t;

    typedef struct packed {
        logic xtal_rdy;
        logic ls_ext;
        logic ls_xtal;
        logic ls_rc;
        logic hs_xtal;
        logic hs_rc;
    } osc_t;
endpackage : clk_ctrl_pkg
`default_nettype wire

// ===== src/level_sync.sv
// three-stage synchroniser that passes a level once the last two stages agree
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;

    // meta_reg feeds s2_reg and nothing else
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta_reg <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            out_reg  <= '0;
        end else begin
            meta_reg <= async_in;
            s2_reg   <= meta_reg;
            s3_reg   <= s2_reg;
            out_reg  <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & out_reg);
        end
    end

    assign sync_out = out_reg;
endmodule : level_sync
`default_nettype wire

// ===== src/system_clock_control.sv
// clock source selection, dividers and register slave of the system clock control block
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`include "clk_ctrl_cfg.svh"
`default_nettype none
module system_clock_control (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        hs_rc_osc_in,
    input  wire logic        hs_xtal_osc_in,
    input  wire logic        xtal_ready_in,
    input  wire logic        ls_rc_osc_in,
    input  wire logic        ls_xtal_osc_in,
    input  wire logic        slow_clock_ext_input_in,
    input  wire logic        sleep_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic             radio_clk_out,
    output logic             periph_clk_out,
    output logic             cpu_clk_out,
    output logic             ls_clk_out,
    output logic             ls_xtal_en_out,
    output logic [7:0]       hs_rc_trim_out,
    output logic [15:0]      ls_rc_cal_out,
    output logic             ls_rc_low_current_out,
    output logic             bus_error_out,
    output logic             irq_out
);
    clk_ctrl_pkg::osc_t      osc_raw;
    clk_ctrl_pkg::osc_t      osc;
    clk_ctrl_pkg::hs_state_t hs_state_reg;
    clk_ctrl_pkg::hs_state_t hs_state_next;

    logic        wr_rdy_reg, wr_busy_reg, bvalid_reg;
    logic        rd_rdy_reg, rd_busy_reg, rvalid_reg;
    logic [1:0]  wcnt_reg, rcnt_reg, bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  hs_mode_reg, ls_src_reg, ls_act_reg;
    logic        req_reg, req_next, sleep_reg;
    logic [2:0]  div_req_reg, div_act_reg;
    logic [7:0]  trim_reg;
    logic [15:0] cal_reg;
    logic        lowi_reg, xen_reg, buserr_reg, irq_reg;
    logic [2:0]  stat_reg, stat_next, mask_reg;
    logic        radio_reg, periph_reg, cpu_reg, ls_clk_reg;
    logic        hs_prev_reg, lsrc_prev_reg, xrdy_prev_reg, ls_run_reg;
    logic [4:0]  div_cnt_reg;
    logic [11:0] run_cnt_reg, run_cnt_next;

    // the oscillators and the amplitude flag are foreign to clk_in
    assign osc_raw = {xtal_ready_in, slow_clock_ext_input_in, ls_xtal_osc_in,
                      ls_rc_osc_in, hs_xtal_osc_in, hs_rc_osc_in};

    level_sync #(
        .WIDTH ($bits(clk_ctrl_pkg::osc_t))
    ) u_osc_sync (
        .clk_in   (clk_in),
        .srst_in  (srst_in),
        .async_in (osc_raw),
        .sync_out (osc)
    );

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= `OFS_IRQ_MASK);
    endfunction : mapped

    function automatic logic ls_pick(input logic [1:0] s, input clk_ctrl_pkg::osc_t o);
        ls_pick = (s == `LS_SRC_RC) ? o.ls_rc : (s == `LS_SRC_XTAL) ? o.ls_xtal : o.ls_ext;
    endfunction : ls_pick

    // ---------------- bus decode ----------------
    wire        wr_take = s_axi_awvalid_in && s_axi_wvalid_in && wr_rdy_reg;
    wire        rd_take = s_axi_arvalid_in && rd_rdy_reg;
    wire        w_map   = mapped(s_axi_awaddr_in);
    wire        r_map   = mapped(s_axi_araddr_in);
    wire        b0      = s_axi_wstrb_in[0];
    wire        wr_hs   = wr_take && s_axi_awaddr_in == `OFS_HS_CTRL && b0;
    wire        wr_trim = wr_take && s_axi_awaddr_in == `OFS_HS_TRIM && b0;
    wire        wr_ls   = wr_take && s_axi_awaddr_in == `OFS_LS_CTRL && b0;
    wire        wr_cal  = wr_take && s_axi_awaddr_in == `OFS_LS_CAL;
    wire        wr_stat = wr_take && s_axi_awaddr_in == `OFS_IRQ_STAT && b0;
    wire        wr_mask = wr_take && s_axi_awaddr_in == `OFS_IRQ_MASK && b0;
    wire [2:0]  wr_div  = s_axi_wdata_in[`F_HS_DIV];
    wire [1:0]  wr_lsrc = s_axi_wdata_in[`F_LS_SRC];
    wire        ls_lock = ls_src_reg != `LS_SRC_RC;
    wire        bus_ev  = (wr_take && !w_map) || (rd_take && !r_map);

    wire [31:0] st_word = {26'h0, ls_act_reg, ls_run_reg, ls_lock, osc.xtal_rdy,
                           hs_state_reg == clk_ctrl_pkg::HS_XTAL};
    wire [7:0]  ra      = s_axi_araddr_in;
    wire [31:0] rd_mux  =
        (ra == `OFS_HS_CTRL)  ? {26'h0, div_req_reg, 1'b0, hs_mode_reg} :
        (ra == `OFS_HS_TRIM)  ? {24'h0, trim_reg} :
        (ra == `OFS_LS_CTRL)  ? {29'h0, lowi_reg, ls_src_reg} :
        (ra == `OFS_LS_CAL)   ? {16'h0, cal_reg} :
        (ra == `OFS_STATUS)   ? st_word :
        (ra == `OFS_IRQ_STAT) ? {29'h0, stat_reg} :
        (ra == `OFS_IRQ_MASK) ? {29'h0, mask_reg} : 32'h0;

    // ---------------- write channel ----------------
    // ready is raised only once address and data are both offered, so neither is taken alone
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_rdy_reg  <= 1'b0;
            wr_busy_reg <= 1'b0;
            wcnt_reg    <= 2'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `RESP_OKAY;
        end else begin
            wr_rdy_reg <= !wr_rdy_reg && !wr_busy_reg && s_axi_awvalid_in && s_axi_wvalid_in;
            if (wr_take) begin
                wr_busy_reg <= 1'b1;
                wcnt_reg    <= 2'(`ACCESS_CYCLES - 2'h1);
                bresp_reg   <= w_map ? `RESP_OKAY : `RESP_DECERR;
            end else if (wcnt_reg != 2'h0) begin
                wcnt_reg <= wcnt_reg - 2'h1;
            end
            if (wcnt_reg == 2'h1) begin
                bvalid_reg <= 1'b1;
            end else if (bvalid_reg && s_axi_bready_in) begin
                bvalid_reg  <= 1'b0;
                wr_busy_reg <= 1'b0;
            end
        end
    end

    // ---------------- read channel ----------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_rdy_reg  <= 1'b0;
            rd_busy_reg <= 1'b0;
            rcnt_reg    <= 2'h0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= `RESP_OKAY;
            rdata_reg   <= 32'h0;
        end else begin
            rd_rdy_reg <= !rd_rdy_reg && !rd_busy_reg && s_axi_arvalid_in;
            if (rd_take) begin
                rd_busy_reg <= 1'b1;
                rcnt_reg    <= 2'(`ACCESS_CYCLES - 2'h1);
                rresp_reg   <= r_map ? `RESP_OKAY : `RESP_DECERR;
                rdata_reg   <= rd_mux;
            end else if (rcnt_reg != 2'h0) begin
                rcnt_reg <= rcnt_reg - 2'h1;
            end
            if (rcnt_reg == 2'h1) begin
                rvalid_reg <= 1'b1;
            end else if (rvalid_reg && s_axi_rready_in) begin
                rvalid_reg  <= 1'b0;
                rd_busy_reg <= 1'b0;
            end
        end
    end

    // ---------------- control registers ----------------
    // trim and calibration are cleared by reset only; sleep and speed changes leave them alone
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            hs_mode_reg <= `RST_HS_MODE;
            div_req_reg <= `RST_DIV;
            trim_reg    <= `RST_TRIM;
            cal_reg     <= `RST_LS_CAL;
            ls_src_reg  <= `LS_SRC_RC;
            lowi_reg    <= 1'b0;
            mask_reg    <= `RST_IRQ_MASK;
        end else begin
            if (wr_hs) begin
                hs_mode_reg <= s_axi_wdata_in[`F_HS_MODE];
                div_req_reg <= (wr_div > `DIV_MAX) ? `DIV_MAX : wr_div;
            end
            if (wr_trim) begin
                trim_reg <= s_axi_wdata_in[`F_TRIM];
            end
            if (wr_ls) begin
                lowi_reg <= s_axi_wdata_in[`F_LS_LOWI];
            end
            // one-way: a crystal or external choice locks the source until reset; value 3 is ignored
            if (wr_ls && !ls_lock && (wr_lsrc == `LS_SRC_XTAL || wr_lsrc == `LS_SRC_EXT)) begin
                ls_src_reg <= wr_lsrc;
            end
            if (wr_cal && s_axi_wstrb_in[0]) begin
                cal_reg[`F_CAL_LO] <= s_axi_wdata_in[7:0];
            end
            if (wr_cal && s_axi_wstrb_in[1]) begin
                cal_reg[`F_CAL_HI] <= s_axi_wdata_in[15:8];
            end
            if (wr_mask) begin
                mask_reg <= s_axi_wdata_in[`F_IRQ];
            end
        end
    end

    // ---------------- fast clock source ----------------
    wire hs_sel  = hs_state_reg == clk_ctrl_pkg::HS_XTAL;
    wire hs_lo   = !osc.hs_rc && !osc.hs_xtal;
    wire hs_want = hs_mode_reg == `HS_MODE_AUTO || req_reg;
    wire hs_lvl  = hs_sel ? osc.hs_xtal : osc.hs_rc;
    wire xswap   = hs_state_reg == clk_ctrl_pkg::HS_SWAP && hs_state_next == clk_ctrl_pkg::HS_XTAL;

    always_comb begin
        hs_state_next = hs_state_reg;
        unique case (hs_state_reg)
            clk_ctrl_pkg::HS_RC: begin
                if (hs_mode_reg == `HS_MODE_AUTO || hs_mode_reg == `HS_MODE_SW) begin
                    hs_state_next = clk_ctrl_pkg::HS_WAIT;
                end
            end
            clk_ctrl_pkg::HS_WAIT: begin
                if (osc.xtal_rdy && hs_want) begin
                    hs_state_next = clk_ctrl_pkg::HS_SWAP;
                end
            end
            clk_ctrl_pkg::HS_SWAP: begin
                if (!osc.xtal_rdy) begin
                    hs_state_next = clk_ctrl_pkg::HS_WAIT;
                end else if (hs_lo) begin
                    hs_state_next = clk_ctrl_pkg::HS_XTAL;
                end
            end
            clk_ctrl_pkg::HS_XTAL: begin
                hs_state_next = clk_ctrl_pkg::HS_XTAL;
            end
        endcase
        if (sleep_reg) begin
            hs_state_next = clk_ctrl_pkg::HS_RC;
        end
    end

    // a request made while still waiting for the crystal is kept; a new one wins over the clear
    assign req_next = (req_reg && !sleep_reg && !hs_sel) || (wr_hs && s_axi_wdata_in[`F_HS_REQ]);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            hs_state_reg <= clk_ctrl_pkg::HS_RC;
            req_reg      <= 1'b0;
            sleep_reg    <= 1'b0;
        end else begin
            hs_state_reg <= hs_state_next;
            req_reg      <= req_next;
            sleep_reg    <= sleep_in;
        end
    end

    // ---------------- fast clock dividers ----------------
    // the divider step is taken only while every derived clock is low, so no runt appears
    wire hs_rise  = hs_lvl && !hs_prev_reg;
    wire div_safe = !hs_lvl && div_cnt_reg == 5'h0;
    wire cpu_lvl  = (div_act_reg == 3'h0) ? hs_lvl : div_cnt_reg[3'(div_act_reg - 3'h1)];

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            hs_prev_reg <= 1'b0;
            div_cnt_reg <= 5'h0;
            div_act_reg <= `RST_DIV;
            radio_reg   <= 1'b0;
            periph_reg  <= 1'b0;
            cpu_reg     <= 1'b0;
        end else begin
            hs_prev_reg <= hs_lvl;
            div_cnt_reg <= div_cnt_reg + {4'h0, hs_rise};
            if (div_safe) begin
                div_act_reg <= div_req_reg;
            end
            radio_reg  <= hs_lvl;
            periph_reg <= div_cnt_reg[0];
            cpu_reg    <= cpu_lvl;
        end
    end

    // ---------------- slow clock ----------------
    wire ls_safe = !ls_pick(ls_act_reg, osc) && !ls_pick(ls_src_reg, osc);
    wire lrc_edg = osc.ls_rc != lsrc_prev_reg;
    assign run_cnt_next = lrc_edg ? 12'h0 :
                          (run_cnt_reg == `LS_RUN_WIN_CYC) ? run_cnt_reg : run_cnt_reg + 12'h1;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ls_act_reg    <= `LS_SRC_RC;
            ls_clk_reg    <= 1'b0;
            xen_reg       <= 1'b0;
            lsrc_prev_reg <= 1'b0;
            run_cnt_reg   <= `LS_RUN_WIN_CYC;
            ls_run_reg    <= 1'b0;
        end else begin
            if (ls_safe) begin
                ls_act_reg <= ls_src_reg;
            end
            ls_clk_reg    <= ls_pick(ls_act_reg, osc);
            xen_reg       <= ls_src_reg == `LS_SRC_XTAL;
            lsrc_prev_reg <= osc.ls_rc;
            run_cnt_reg   <= run_cnt_next;
            // software reads this before trusting the RC oscillator
            ls_run_reg    <= run_cnt_next < `LS_RUN_WIN_CYC;
        end
    end

    // ---------------- interrupts ----------------
    wire [2:0] ev  = {osc.xtal_rdy && !xrdy_prev_reg, xswap, bus_ev};
    wire [2:0] clr = wr_stat ? s_axi_wdata_in[`F_IRQ] : 3'h0;
    assign stat_next = (stat_reg & ~clr) | ev;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            stat_reg      <= 3'h0;
            xrdy_prev_reg <= 1'b0;
            buserr_reg    <= 1'b0;
            irq_reg       <= 1'b0;
        end else begin
            stat_reg      <= stat_next;
            xrdy_prev_reg <= osc.xtal_rdy;
            buserr_reg    <= bus_ev;
            irq_reg       <= |(stat_next & mask_reg);
        end
    end

    assign s_axi_awready_out     = wr_rdy_reg;
    assign s_axi_wready_out      = wr_rdy_reg;
    assign s_axi_bresp_out       = bresp_reg;
    assign s_axi_bvalid_out      = bvalid_reg;
    assign s_axi_arready_out     = rd_rdy_reg;
    assign s_axi_rdata_out       = rdata_reg;
    assign s_axi_rresp_out       = rresp_reg;
    assign s_axi_rvalid_out      = rvalid_reg;
    assign radio_clk_out         = radio_reg;
    assign periph_clk_out        = periph_reg;
    assign cpu_clk_out           = cpu_reg;
    assign ls_clk_out            = ls_clk_reg;
    assign ls_xtal_en_out        = xen_reg;
    assign hs_rc_trim_out        = trim_reg;
    assign ls_rc_cal_out         = cal_reg;
    assign ls_rc_low_current_out = lowi_reg;
    assign bus_error_out         = buserr_reg;
    assign irq_out               = irq_reg;

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    write_latency_a: assert property (wr_take |-> !s_axi_bvalid_out [*3] ##0 1'b1 ##1 s_axi_bvalid_out)
        else $error("write answer not three cycles after take");
    read_latency_a: assert property (rd_take |-> ##3 s_axi_rvalid_out ##0 $past(!s_axi_rvalid_out))
        else $error("read answer not three cycles after take");
    unmapped_decerr_a: assert property (rd_take && !r_map |-> ##3 s_axi_rresp_out == `RESP_DECERR)
        else $error("unmapped read without error response");
    bus_error_a: assert property ((wr_take && !w_map) |=> bus_error_out ##1 stat_reg[`IRQ_BUSERR])
        else $error("bus error not flagged");
    sleep_rc_a: assert property (sleep_reg |=> !hs_sel)
        else $error("fast clock not on RC after sleep");
    xtal_gate_a: assert property ($rose(hs_sel) |-> $past(osc.xtal_rdy))
        else $error("crystal selected before ready");
    ls_lock_a: assert property (ls_lock |=> $stable(ls_src_reg))
        else $error("slow source changed after lock");
    hs_glitch_a: assert property ($rose(hs_sel) |-> !radio_clk_out)
        else $error("fast source switched while clock high");
endmodule : system_clock_control
`default_nettype wire

// ===== sim/system_clock_control_bench.sv
// self-checking bench of the system clock control block
`include "clk_ctrl_cfg.svh"
`default_nettype none
module system_clock_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        xtal_rdy = 1'b0;
    logic        sleep = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [7:0]  cnt = 8'h00, awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v, r;
    logic        awready, wready, bvalid, arready, rvalid, xen, lowi, berr, irq;
    logic [1:0]  bresp, rresp, resp;
    logic [7:0]  trim;
    logic [15:0] cal;
    int          n_mismatch = 0, comparisons = 0, n_berr = 0, b0, lat, seed = 32'h7bb9;
    logic [7:0]  bad [3] = '{8'h1c, 8'h02, 8'hfc};
    // generated clocks: [3] radio, [2] peripheral, [1] processor, [0] slow
    logic [3:0]  clks, clk_q = 4'h0;
    int          n_rise [4] = '{0, 0, 0, 0};

    always #10 clk_in = ~clk_in;
    // oscillators run far below the sampling clock so every phase is seen
    always @(posedge clk_in) cnt <= cnt + 8'h01;
    always @(posedge clk_in) if (berr === 1'b1) n_berr <= n_berr + 1;
    always @(posedge clk_in) begin
        clk_q <= clks;
        foreach (n_rise[i]) n_rise[i] <= n_rise[i] + int'(clks[i] && !clk_q[i]);
    end

    system_clock_control dut (.clk_in(clk_in), .srst_in(srst_in), .hs_rc_osc_in(cnt[1]),
        .hs_xtal_osc_in(cnt[2]), .xtal_ready_in(xtal_rdy), .ls_rc_osc_in(cnt[4]),
        .ls_xtal_osc_in(cnt[5]), .slow_clock_ext_input_in(cnt[3]), .sleep_in(sleep),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .radio_clk_out(clks[3]), .periph_clk_out(clks[2]), .cpu_clk_out(clks[1]),
        .ls_clk_out(clks[0]), .ls_xtal_en_out(xen), .hs_rc_trim_out(trim), .ls_rc_cal_out(cal),
        .ls_rc_low_current_out(lowi), .bus_error_out(berr), .irq_out(irq));

    function automatic logic [31:0] hs_exp(input int e, input logic [1:0] m);
        return {26'h0, (e > 5) ? 3'h5 : 3'(e), 1'b0, m};
    endfunction : hs_exp

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // lat counts falling edges after the taking edge until the answer shows
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do @(negedge clk_in); while (awready !== 1'b1);
        @(posedge clk_in);
        awv <= 1'b0;
        wv <= 1'b0;
        lat = 0;
        do begin @(negedge clk_in); lat++; end while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge clk_in);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk_in); while (arready !== 1'b1);
        @(posedge clk_in);
        arv <= 1'b0;
        lat = 0;
        do begin @(negedge clk_in); lat++; end while (rvalid !== 1'b1);
        resp = rresp;
        r = rdata;
        @(posedge clk_in);
        rready <= 1'b0;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask : idle

    // rising edges over 256 cycles; call on a falling edge so exactly 256 samples are counted
    task automatic clk_win(input int r_exp, input int p_exp, input int c_exp, input int l_exp);
        int base [4];
        base = n_rise;
        idle(256);
        chk(n_rise[3] - base[3], r_exp);
        chk(n_rise[2] - base[2], p_exp);
        chk(n_rise[1] - base[1], c_exp);
        chk(n_rise[0] - base[0], l_exp);
    endtask : clk_win

    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test

    initial begin
        repeat (30000) @(posedge clk_in);
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge clk_in);
        srst_in <= 1'b0;
        idle(8);
        chk(32'(xen), 32'h0);
        rd(`OFS_HS_CTRL);
        chk(r, 32'h0);
        rd(`OFS_LS_CTRL);
        chk(r, 32'h0);
        rd(`OFS_STATUS);
        chk(32'(r[3]), 32'h1);
        $display("test reset done");
        for (int e = 0; e < 8; e++) begin
            wr(`OFS_HS_CTRL, {26'h0, 3'(e), 3'h6});
            chk(lat, 3);
            rd(`OFS_HS_CTRL);
            chk(lat, 3);
            chk(r, hs_exp(e, 2'h2));
        end
        // the new divide applies only at the counter wrap, up to 128 cycles later
        idle(150);
        clk_win(64, 32, 2, 8);
        $display("test divider done");
        v = $random(seed);
        wr(`OFS_HS_TRIM, v);
        wr(`OFS_LS_CAL, v);
        wr(`OFS_LS_CTRL, 32'h5);
        idle(80);
        chk(32'(trim), 32'(v[7:0]));
        chk(32'(cal), 32'(v[15:0]));
        chk(32'(lowi), 32'h1);
        chk(32'(xen), 32'h1);
        wr(`OFS_LS_CTRL, 32'h2);
        idle(80);
        chk(32'(xen), 32'h1);
        rd(`OFS_STATUS);
        chk(32'(r[5:4]), 32'h1);
        $display("test slow source done");
        wr(`OFS_IRQ_MASK, 32'h1);
        b0 = n_berr;
        foreach (bad[i]) begin
            wr(bad[i], $random(seed));
            chk(resp, `RESP_DECERR);
            rd(bad[i]);
            chk(resp, `RESP_DECERR);
            chk(r, 32'h0);
        end
        idle(3);
        chk(n_berr - b0, 6);
        chk(32'(irq), 32'h1);
        wr(`OFS_IRQ_STAT, 32'h1);
        idle(3);
        chk(32'(irq), 32'h0);
        $display("test bus error done");
        wr(`OFS_HS_CTRL, 32'h0);
        idle(80);
        rd(`OFS_STATUS);
        chk(32'(r[0]), 32'h0);
        xtal_rdy <= 1'b1;
        idle(80);
        rd(`OFS_STATUS);
        chk(32'(r[0]), 32'h1);
        rd(`OFS_IRQ_STAT);
        chk(r, 32'h6);
        idle(8);
        clk_win(32, 16, 32, 4);
        wr(`OFS_HS_CTRL, 32'h2);
        @(posedge clk_in);
        sleep <= 1'b1;
        repeat (2) @(posedge clk_in);
        sleep <= 1'b0;
        idle(80);
        rd(`OFS_STATUS);
        chk(32'(r[0]), 32'h0);
        chk(32'(trim), 32'(v[7:0]));
        wr(`OFS_HS_CTRL, 32'h1);
        idle(80);
        rd(`OFS_STATUS);
        chk(32'(r[0]), 32'h0);
        wr(`OFS_HS_CTRL, 32'h5);
        idle(80);
        rd(`OFS_STATUS);
        chk(32'(r[0]), 32'h1);
        $display("test fast switch done");
        srst_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        idle(8);
        chk(32'(xen), 32'h0);
        rd(`OFS_LS_CTRL);
        chk(r, 32'h0);
        $display("test second reset done");
        finish_test();
    end
endmodule : system_clock_control_bench
`default_nettype wire
